// ==== pnc_codec.sv ====
// Number format codec between command words and fixed-point quantities.
// Fixed-point side is signed with FRAC_W fraction bits; one clock, async reset.
// What this block does
// - Linear 5/11 exponent is word bits 15:11, signed, scales mantissa by two power.
// - Linear 5/11 mantissa is word bits 10:0, signed, -1024 to +1023.
// - Unsigned linear uses all sixteen bits, exponent fixed at minus twelve.
// - Bitfield formats pass 16 or 8 bits with no conversion.
// - Integer word is the 16-bit field as unsigned, unscaled.
// - Text format passes 8-bit Latin-1 characters, variable length.
// - Custom format decodes as signed or unsigned word times per-command scale; encode passes the low 16 bits unscaled.
`timescale 1ns/1ps
`default_nettype none
module pnc_codec (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_valid,
    input wire logic i_encode,
    input wire pnc_pkg::pnc_fmt_t i_fmt,
    input wire logic i_byte_wide,
    input wire logic i_custom_signed,
    input wire logic [pnc_pkg::SCALE_W-1:0] i_custom_scale,
    input wire logic [pnc_pkg::WORD_W-1:0] i_word,
    input wire logic signed [pnc_pkg::FIXED_W-1:0] i_value,
    output logic o_valid,
    output logic [pnc_pkg::WORD_W-1:0] o_word,
    output logic signed [pnc_pkg::FIXED_W-1:0] o_value,
    output logic o_char_valid,
    output logic [pnc_pkg::BYTE_W-1:0] o_char
);
    ////////////////////////////////////////////////////////////////
    logic signed [pnc_pkg::EXP_W-1:0] dec_exp;
    logic signed [pnc_pkg::MANT_W-1:0] dec_mant;
    logic signed [pnc_pkg::FIXED_W-1:0] mant_ext;
    logic signed [pnc_pkg::FIXED_W-1:0] dec_l11;
    logic [pnc_pkg::WORD_W-1:0] l11_word;
    logic signed [pnc_pkg::FIXED_W-1:0] custom_prod;
    logic [pnc_pkg::WORD_W-1:0] word_next, word_reg;
    logic signed [pnc_pkg::FIXED_W-1:0] value_next, value_reg;
    logic valid_next, valid_reg;
    logic char_valid_next, char_valid_reg;
    logic [pnc_pkg::BYTE_W-1:0] char_next, char_reg;

    pnc_l11_enc u_enc (
        .i_value(i_value),
        .o_word(l11_word)
    );

    ////////////////////////////////////////////////////////////////
    always_comb
    begin
        dec_exp = i_word[pnc_pkg::EXP_MSB:pnc_pkg::EXP_LSB];
        dec_mant = i_word[pnc_pkg::MANT_MSB:0];
        mant_ext = pnc_pkg::FIXED_W'(dec_mant);
        // Result carries FRAC_W fraction bits; shift by exponent plus FRAC_W
        if (dec_exp + 6'sd12 >= 0)
            dec_l11 = mant_ext <<< (dec_exp + 6'sd12);
        else
            dec_l11 = mant_ext >>> (-(dec_exp + 6'sd12));
        // Custom: unsigned or signed word times per-command constant, integer result
        // Widen both operands first so the product is formed at full width, not at 16 or 17 bits
        if (i_custom_signed)
            custom_prod = $signed({{(pnc_pkg::FIXED_W-pnc_pkg::WORD_W){i_word[pnc_pkg::WORD_W-1]}}, i_word})
                          * $signed({{(pnc_pkg::FIXED_W-pnc_pkg::SCALE_W){1'b0}}, i_custom_scale});
        else
            custom_prod = $signed({{(pnc_pkg::FIXED_W-pnc_pkg::WORD_W){1'b0}}, i_word}
                          * {{(pnc_pkg::FIXED_W-pnc_pkg::SCALE_W){1'b0}}, i_custom_scale});
    end

    ////////////////////////////////////////////////////////////////
    always_comb
    begin
        valid_next = i_valid;
        word_next = word_reg;
        value_next = value_reg;
        char_valid_next = 1'b0;
        char_next = char_reg;
        if (i_valid)
        begin
            case (i_fmt)
                pnc_pkg::FMT_LINEAR_EXP5_MANT11:
                begin
                    if (i_encode)
                        word_next = l11_word;
                    else
                        value_next = dec_l11;
                end
                pnc_pkg::FMT_LINEAR_UNSIGNED_FIXED_EXP:
                begin
                    // Fixed exponent equals minus FRAC_W, so the raw word is already the fixed-point value
                    if (i_encode)
                    begin
                        if (i_value < 0)
                            word_next = '0;
                        else if (i_value > $signed(pnc_pkg::FIXED_W'(16'hFFFF)))
                            word_next = 16'hFFFF;
                        else
                            word_next = i_value[pnc_pkg::WORD_W-1:0];
                    end
                    else
                        value_next = $signed({16'h0000, i_word});
                end
                pnc_pkg::FMT_BITFIELD:
                begin
                    // No numeric meaning; upper byte zeroed in byte mode
                    if (i_encode)
                        word_next = i_byte_wide ? {8'h00, i_value[pnc_pkg::BYTE_W-1:0]}
                                                : i_value[pnc_pkg::WORD_W-1:0];
                    else
                        value_next = i_byte_wide ? $signed({24'h000000, i_word[pnc_pkg::BYTE_W-1:0]})
                                                 : $signed({16'h0000, i_word});
                end
                pnc_pkg::FMT_INTEGER_WORD:
                begin
                    if (i_encode)
                        word_next = i_value[pnc_pkg::WORD_W-1:0];
                    else
                        value_next = $signed({16'h0000, i_word});
                end
                pnc_pkg::FMT_CUSTOM_SCALED:
                begin
                    if (i_encode)
                        word_next = i_value[pnc_pkg::WORD_W-1:0];
                    else
                        value_next = custom_prod;
                end
                pnc_pkg::FMT_LATIN1_TEXT:
                begin
                    // One character per valid beat; string length is the caller's framing
                    char_valid_next = 1'b1;
                    char_next = i_encode ? i_value[pnc_pkg::BYTE_W-1:0]
                                         : i_word[pnc_pkg::BYTE_W-1:0];
                    word_next = {8'h00, char_next};
                end
                default:
                begin
                    word_next = word_reg;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            valid_reg <= 1'b0;
            word_reg <= '0;
            value_reg <= '0;
            char_valid_reg <= 1'b0;
            char_reg <= '0;
        end
        else
        begin
            valid_reg <= valid_next;
            word_reg <= word_next;
            value_reg <= value_next;
            char_valid_reg <= char_valid_next;
            char_reg <= char_next;
        end
    end

    assign o_valid = valid_reg;
    assign o_word = word_reg;
    assign o_value = value_reg;
    assign o_char_valid = char_valid_reg;
    assign o_char = char_reg;
endmodule : pnc_codec
`default_nettype wire

// ==== pnc_pkg.sv ====
// Constants and types for the number format codec.
// Assumes one 20 MHz clock; no software-visible registers.
package pnc_pkg;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int EXP_W = 5;
    localparam int MANT_W = 11;
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam int MANT_MSB = 10;
    localparam int FIXED_W = 32;
    localparam int FRAC_W = 12;
    localparam logic signed [EXP_W-1:0] UNSIGNED_FIXED_EXP = 5'sh14;
    localparam logic signed [EXP_W-1:0] EXP_MIN = 5'sh10;
    localparam logic signed [EXP_W-1:0] EXP_MAX = 5'sh0F;
    localparam logic signed [MANT_W-1:0] MANT_MAX = 11'sh3FF;
    localparam logic signed [MANT_W-1:0] MANT_MIN = 11'sh400;
    localparam int SCALE_W = 16;

    typedef enum logic [5:0] {
        FMT_LINEAR_EXP5_MANT11 = 6'h01,
        FMT_LINEAR_UNSIGNED_FIXED_EXP = 6'h02,
        FMT_BITFIELD = 6'h04,
        FMT_INTEGER_WORD = 6'h08,
        FMT_CUSTOM_SCALED = 6'h10,
        FMT_LATIN1_TEXT = 6'h20
    } pnc_fmt_t;
endpackage : pnc_pkg

// ==== pnc_l11_enc.sv ====
// Linear 5/11 encoder: signed fixed-point value with FRAC_W fraction bits.
// Combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module pnc_l11_enc (
    input wire logic signed [pnc_pkg::FIXED_W-1:0] i_value,
    output logic [pnc_pkg::WORD_W-1:0] o_word
);
    logic signed [pnc_pkg::FIXED_W-1:0] m;
    logic signed [pnc_pkg::EXP_W-1:0] e;
    logic signed [pnc_pkg::MANT_W-1:0] mant;
    logic done;
    always_comb
    begin
        // Start at exponent minus twelve (no shift), coarsen until the mantissa fits
        m = i_value;
        e = pnc_pkg::UNSIGNED_FIXED_EXP;
        done = 1'b0;
        for (int k = 0; k < 28; k++)
        begin
            if (!done && (m > $signed({{(pnc_pkg::FIXED_W-pnc_pkg::MANT_W){1'b0}}, pnc_pkg::MANT_MAX})
                || m < $signed({{(pnc_pkg::FIXED_W-pnc_pkg::MANT_W){1'b1}}, pnc_pkg::MANT_MIN})))
            begin
                if (e == pnc_pkg::EXP_MAX)
                    done = 1'b1;
                else
                begin
                    m = m >>> 1;
                    e = e + 5'sh01;
                end
            end
        end
        // Too large even at the top exponent: saturate
        if (m > $signed({{(pnc_pkg::FIXED_W-pnc_pkg::MANT_W){1'b0}}, pnc_pkg::MANT_MAX}))
            mant = pnc_pkg::MANT_MAX;
        else if (m < $signed({{(pnc_pkg::FIXED_W-pnc_pkg::MANT_W){1'b1}}, pnc_pkg::MANT_MIN}))
            mant = pnc_pkg::MANT_MIN;
        else
            mant = m[pnc_pkg::MANT_W-1:0];
        o_word = {e, mant};
    end
endmodule : pnc_l11_enc
`default_nettype wire

// ==== pnc_codec_chk.sv ====
// Port checker for the number format codec.
// Assumes one clock and async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pnc_codec_chk (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_valid,
    input wire logic i_encode,
    input wire pnc_pkg::pnc_fmt_t i_fmt,
    input wire logic i_byte_wide,
    input wire logic i_custom_signed,
    input wire logic [pnc_pkg::SCALE_W-1:0] i_custom_scale,
    input wire logic [pnc_pkg::WORD_W-1:0] i_word,
    input wire logic signed [pnc_pkg::FIXED_W-1:0] i_value,
    input wire logic o_valid,
    input wire logic [pnc_pkg::WORD_W-1:0] o_word,
    input wire logic signed [pnc_pkg::FIXED_W-1:0] o_value,
    input wire logic o_char_valid
);
    logic dec;
    assign dec = i_valid && !i_encode;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    a_valid_follows: assert property (i_valid |=> o_valid) else $error("answer missing");
    a_valid_quiet: assert property (!i_valid |=> !o_valid) else $error("stray answer");
    a_lin_exp_zero: assert property (dec && i_fmt == pnc_pkg::FMT_LINEAR_EXP5_MANT11 && i_word[15:11] == 5'h00
        |=> o_value == ($signed($past(i_word[10:0])) <<< 12)) else $error("linear decode wrong");
    a_fixed_exp_raw: assert property (dec && i_fmt == pnc_pkg::FMT_LINEAR_UNSIGNED_FIXED_EXP
        |=> o_value == {16'h0000, $past(i_word)}) else $error("unsigned linear wrong");
    a_int_word_raw: assert property (dec && i_fmt == pnc_pkg::FMT_INTEGER_WORD
        |=> o_value == {16'h0000, $past(i_word)}) else $error("integer word wrong");
    a_byte_field: assert property (dec && i_fmt == pnc_pkg::FMT_BITFIELD && i_byte_wide
        |=> o_value == {24'h000000, $past(i_word[7:0])}) else $error("byte field wrong");
    a_custom_unsigned: assert property (dec && i_fmt == pnc_pkg::FMT_CUSTOM_SCALED && !i_custom_signed
        |=> o_value == $past(i_word) * $past(i_custom_scale)) else $error("custom wrong");
    a_text_pulse: assert property (i_valid && i_fmt == pnc_pkg::FMT_LATIN1_TEXT |=> o_char_valid) else $error("no char");
    a_enc_sign_kept: assert property (i_valid && i_encode && i_fmt == pnc_pkg::FMT_LINEAR_EXP5_MANT11
        |=> o_word[10] == $past(i_value[31])) else $error("encode sign lost");
endmodule : pnc_codec_chk
bind pnc_codec pnc_codec_chk i_pnc_codec_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_valid(i_valid),
    .i_encode(i_encode), .i_fmt(i_fmt), .i_byte_wide(i_byte_wide), .i_custom_signed(i_custom_signed),
    .i_custom_scale(i_custom_scale), .i_word(i_word), .i_value(i_value), .o_valid(o_valid),
    .o_word(o_word), .o_value(o_value), .o_char_valid(o_char_valid));
`default_nettype wire

// ==== pnc_text_sink.sv ====
// Far-side text sink: counts received characters and keeps the last one.
// Assumes the codec's one clock.
`timescale 1ns/1ps
`default_nettype none
module pnc_text_sink (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_char_valid,
    input wire logic [7:0] i_char,
    output var int o_count,
    output var logic [7:0] o_last
);
    always_ff @(posedge i_clk or negedge i_resetn)
        if (!i_resetn) o_count <= 0;
        else if (i_char_valid) o_count <= o_count + 1;
    always_ff @(posedge i_clk)
        if (i_char_valid) o_last <= i_char;
endmodule : pnc_text_sink
`default_nettype wire

// ==== test_pnc_codec.sv ====
// Self-checking bench for the number format codec.
// Assumes a 50 ns clock and the text sink as far side.
`timescale 1ns/1ps
`default_nettype none
module test_pnc_codec;
    logic i_clk = 0, i_resetn = 0, i_valid = 0, i_encode = 0, i_byte_wide = 0, i_custom_signed = 0;
    pnc_pkg::pnc_fmt_t i_fmt = pnc_pkg::FMT_INTEGER_WORD;
    logic [15:0] i_custom_scale = 16'h0000, i_word = 16'h0000;
    logic signed [31:0] i_value = 32'h00000000, o_value;
    logic o_valid, o_char_valid;
    logic [15:0] o_word;
    logic [7:0] o_char, last;
    int fail_count = 0, compares = 0, chars;
    always #25 i_clk = ~i_clk;
    pnc_codec i_pnc_codec (.i_clk(i_clk), .i_resetn(i_resetn), .i_valid(i_valid), .i_encode(i_encode),
        .i_fmt(i_fmt), .i_byte_wide(i_byte_wide), .i_custom_signed(i_custom_signed),
        .i_custom_scale(i_custom_scale), .i_word(i_word), .i_value(i_value), .o_valid(o_valid),
        .o_word(o_word), .o_value(o_value), .o_char_valid(o_char_valid), .o_char(o_char));
    pnc_text_sink i_pnc_text_sink (.i_clk(i_clk), .i_resetn(i_resetn), .i_char_valid(o_char_valid),
        .i_char(o_char), .o_count(chars), .o_last(last));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask : chk
    // One request; the answer is looked at in its single valid cycle
    task req(input logic enc, input pnc_pkg::pnc_fmt_t f, input logic [15:0] w, input logic [31:0] v);
        @(posedge i_clk);
        i_valid <= 1'h1; i_encode <= enc; i_fmt <= f; i_word <= w; i_value <= v;
        @(posedge i_clk);
        i_valid <= 1'h0;
        #1 chk("o_valid", 32'h1, {31'h0, o_valid});
    endtask : req
    task t_lin_decode;
        req(1'h0, pnc_pkg::FMT_LINEAR_EXP5_MANT11, 16'h9807, 32'h0);
        chk("lin pos", 32'h00000003, o_value);
        req(1'h0, pnc_pkg::FMT_LINEAR_EXP5_MANT11, 16'h0400, 32'h0);
        chk("lin min", 32'hFFC00000, o_value);
    endtask : t_lin_decode
    task t_lin_encode;
        req(1'h1, pnc_pkg::FMT_LINEAR_EXP5_MANT11, 16'h0000, 32'h00001000);
        chk("enc one", 32'h0000BA00, {16'h0, o_word});
        req(1'h1, pnc_pkg::FMT_LINEAR_EXP5_MANT11, 16'h0000, 32'h7FFFFFFF);
        chk("enc max", 32'h00004BFF, {16'h0, o_word});
    endtask : t_lin_encode
    task t_plain_words;
        req(1'h0, pnc_pkg::FMT_LINEAR_UNSIGNED_FIXED_EXP, 16'h9800, 32'h0);
        chk("unsigned lin", 32'h00009800, o_value);
        req(1'h0, pnc_pkg::FMT_INTEGER_WORD, 16'h9807, 32'h0);
        chk("int word", 32'h00009807, o_value);
    endtask : t_plain_words
    task t_fields;
        i_byte_wide <= 1'h1;
        req(1'h0, pnc_pkg::FMT_BITFIELD, 16'hA5C3, 32'h0);
        chk("byte field", 32'h000000C3, o_value);
        i_byte_wide <= 1'h0;
        req(1'h0, pnc_pkg::FMT_BITFIELD, 16'hA5C3, 32'h0);
        chk("word field", 32'h0000A5C3, o_value);
    endtask : t_fields
    task t_custom;
        i_custom_scale <= 16'h03E8;
        req(1'h0, pnc_pkg::FMT_CUSTOM_SCALED, 16'h0003, 32'h0);
        chk("custom uns", 32'h00000BB8, o_value);
        i_custom_signed <= 1'h1; i_custom_scale <= 16'h0005;
        req(1'h0, pnc_pkg::FMT_CUSTOM_SCALED, 16'hFFFE, 32'h0);
        chk("custom sgn", 32'hFFFFFFF6, o_value);
    endtask : t_custom
    task t_encodes;
        req(1'h1, pnc_pkg::FMT_LINEAR_UNSIGNED_FIXED_EXP, 16'h0000, 32'h00009800);
        chk("unsigned enc", 32'h00009800, {16'h0, o_word});
        req(1'h1, pnc_pkg::FMT_LINEAR_UNSIGNED_FIXED_EXP, 16'h0000, 32'hFFFFFFFF);
        chk("unsigned clamp", 32'h00000000, {16'h0, o_word});
        req(1'h1, pnc_pkg::FMT_INTEGER_WORD, 16'h0000, 32'h00019807);
        chk("int enc", 32'h00009807, {16'h0, o_word});
        i_byte_wide <= 1'h1;
        req(1'h1, pnc_pkg::FMT_BITFIELD, 16'h0000, 32'h0000A5C3);
        chk("byte enc", 32'h000000C3, {16'h0, o_word});
        i_byte_wide <= 1'h0;
        i_custom_signed <= 1'h0; i_custom_scale <= 16'h1000;
        req(1'h0, pnc_pkg::FMT_CUSTOM_SCALED, 16'h1234, 32'h0);
        chk("custom wide", 32'h01234000, o_value);
    endtask : t_encodes
    task t_text;
        req(1'h1, pnc_pkg::FMT_LATIN1_TEXT, 16'h00E9, 32'h000000E9);
        chk("char", 32'h000000E9, {24'h0, o_char});
        req(1'h1, pnc_pkg::FMT_LATIN1_TEXT, 16'h0041, 32'h00000041);
        @(posedge i_clk);
        #1 chk("sink count", 32'h2, chars);
        chk("sink last", 32'h41, {24'h0, last});
    endtask : t_text
    task wrap_up;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_resetn <= 1'h1;
        t_lin_decode(); t_lin_encode(); t_plain_words(); t_fields(); t_custom(); t_encodes(); t_text();
        wrap_up();
    end
    // About 50 cycles of tests; the limit leaves wide margin
    initial
    begin
        #100000;
        fail_count++;
        wrap_up();
    end
endmodule : test_pnc_codec
`default_nettype wire
